// ---- core/paged_spi_register_port.sv ----
// serial slave port, paged registers, FIR filter bank and data-ready pin
// assumes serial pins are asynchronous to clock_i and oversampled by it
`timescale 1ns/100ps
`default_nettype none
module paged_spi_register_port
  import imu_port_pkg::*;
#(
  parameter logic [15:0] SERIAL_NUMBER = 16'h1234, // arbitrary value
  parameter int STARTUP_CNT = STARTUP_CYCLES
) (
  input wire logic clock_i,                    // core clock, 250 MHz
  input wire logic resetn_i,                   // async reset, active low
  input wire logic sclk_i,                     // serial clock pin
  input wire logic cs_n_i,                     // chip select pin, active low
  input wire logic mosi_i,                     // serial data in pin
  output logic miso_o,                         // serial data out
  output logic miso_oe_o,                      // serial out drive enable
  input wire logic sample_valid_i,             // calibrated set strobe
  input wire sample_set_s sample_i,            // calibrated samples
  input wire logic [2:0][DATA_W-1:0] pop_term_i, // percussion correction
  output logic [3:0] multipurpose_pin_o,       // multipurpose pin levels
  output logic [3:0] multipurpose_pin_oe_o,    // multipurpose drive enables
  output logic producing_o                     // data production running
);

  typedef enum logic [1:0] {F_IDLE, F_MAC, F_DONE} fir_state_e;

  // coefficient index for a page code and word; shared by read and write
  function automatic logic [COEF_IDX_W-1:0] coef_index(input logic [7:0] pg,
                                                      input logic [5:0] wd);
    logic [7:0] rel;
    rel = pg - PG_COEF_FIRST;
    coef_index = COEF_IDX_W'(rel[7:1]) * COEF_IDX_W'(TAPS)
               + (rel[0] ? COEF_IDX_W'(COEF_PER_PAGE) : '0)
               + COEF_IDX_W'(wd - COEF_BASE_WORD);
  endfunction : coef_index

  function automatic logic [15:0] merge_byte(input logic [15:0] old,
                                             input logic hi, input logic [7:0] b);
    merge_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : merge_byte

  // pin synchronisers
  logic [1:0] sclk_s_q, cs_s_q, mosi_s_q;
  logic sclk_prev_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_s_q <= 2'b11;
      cs_s_q <= 2'b11;
      mosi_s_q <= 2'b00;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      cs_s_q <= {cs_s_q[0], cs_n_i};
      mosi_s_q <= {mosi_s_q[0], mosi_i};
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  wire selected = !cs_s_q[1];
  wire sclk_rise = selected && sclk_s_q[1] && !sclk_prev_q; // [R16]
  wire sclk_fall = selected && !sclk_s_q[1] && sclk_prev_q; // [R16]

  // serial shifter
  logic [3:0] bit_cnt_q;
  logic [FRAME_BITS-2:0] rx_q;
  logic [FRAME_BITS-1:0] tx_q;
  logic miso_q;
  wire frame_done = sclk_rise && (bit_cnt_q == 4'hF);
  wire spi_frame_s frame = {rx_q, mosi_s_q[1]}; // [R17]
  wire [5:0] word = frame.addr[ADDR_W-1:1];     // [R8]
  wire hi_byte = frame.addr[0];
  wire is_write = frame_done && frame.write;   // [R25]
  wire is_read = frame_done && !frame.write;   // [R24]

  // registers
  logic [15:0] page_q, pin_func_q, calib_opt_q, avg_count_q, bank_low_q, bank_high_q;
  logic [15:0] coef_q [BANKS*TAPS];
  logic [SENSORS-1:0][DATA_W-1:0] out_q;
  logic [15:0] rd_word;

  wire [7:0] page = page_q[7:0];
  wire on_coef_page = (page >= PG_COEF_FIRST) && (page <= PG_COEF_LAST); // [R12]
  // widened so that base plus count cannot wrap to zero
  wire coef_word = on_coef_page && (word >= COEF_BASE_WORD)
                 && (ADDR_W'(word) < ADDR_W'(COEF_BASE_WORD) + ADDR_W'(COEF_PER_PAGE));
  wire out_word = (page == PG_OUTPUT) && (word >= REG_OUT_BASE)
                && (word < REG_OUT_BASE + 6'(SENSORS));
  wire [2:0] out_sel = 3'(word - REG_OUT_BASE);
  wire [COEF_IDX_W-1:0] host_coef_idx = coef_index(page, word);
  wire ctl_page = (page == PG_CONTROL);
  wire soft_reset = is_write && ctl_page && (word == REG_GLOBAL_CMD)
                  && !hi_byte && frame.data[SOFT_RESET_BIT]; // [R22]

  // only the active page is decoded [R9]
  always_comb begin
    rd_word = 16'h0000;
    if (word == REG_PAGE_SELECT) begin
      rd_word = page_q; // [R10] [R11]
    end else if (out_word) begin
      rd_word = out_q[out_sel];
    end else if (coef_word) begin
      rd_word = coef_q[host_coef_idx];
    end else if (page == PG_SERIAL && word == REG_SERIAL) begin
      rd_word = SERIAL_NUMBER;
    end else if (ctl_page) begin
      case (word)
        REG_PIN_FUNCTION: rd_word = pin_func_q;
        REG_CALIB_OPTION: rd_word = calib_opt_q;
        REG_AVG_COUNT: rd_word = avg_count_q;
        REG_BANK_LOW: rd_word = bank_low_q;
        REG_BANK_HIGH: rd_word = bank_high_q;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_q <= 4'h0;
      rx_q <= '0;
      tx_q <= '0;
      miso_q <= 1'b0;
    end else if (!selected) begin
      bit_cnt_q <= 4'h0;
    end else begin
      if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        rx_q <= {rx_q[FRAME_BITS-3:0], mosi_s_q[1]}; // [R17]
      end
      if (frame_done) begin
        tx_q <= is_read ? rd_word : 16'h0000; // [R13] [R23]
      end else if (sclk_fall) begin
        miso_q <= tx_q[FRAME_BITS-1]; // [R16] [R17]
        tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  assign miso_oe_o = selected; // [R14]
  assign miso_o = selected ? miso_q : 1'b0;

  // control register writes; page 1, outputs and serial page ignore writes [R26]
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_q <= {8'h00, PG_OUTPUT};
      pin_func_q <= PIN_FUNCTION_RESET;
      calib_opt_q <= CALIB_OPTION_RESET;
      avg_count_q <= AVG_COUNT_RESET;
      bank_low_q <= BANK_CHOICE_RESET;
      bank_high_q <= BANK_CHOICE_RESET;
    end else if (is_write) begin
      if (word == REG_PAGE_SELECT) begin
        if (!hi_byte) page_q <= {8'h00, frame.data}; // [R10] [R7]
      end else if (ctl_page) begin
        case (word)
          REG_PIN_FUNCTION: pin_func_q <= merge_byte(pin_func_q, hi_byte, frame.data);
          REG_CALIB_OPTION: calib_opt_q <= merge_byte(calib_opt_q, hi_byte, frame.data);
          REG_AVG_COUNT: avg_count_q <= merge_byte(avg_count_q, hi_byte, frame.data);
          REG_BANK_LOW: bank_low_q <= merge_byte(bank_low_q, hi_byte, frame.data);
          REG_BANK_HIGH: bank_high_q <= merge_byte(bank_high_q, hi_byte, frame.data);
          default: ;
        endcase
      end
    end
  end

  // production start-up after pin or software reset
  logic [$clog2(STARTUP_CNT+1)-1:0] start_cnt_q;
  wire producing = (start_cnt_q == '0);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_cnt_q <= ($clog2(STARTUP_CNT+1))'(STARTUP_CNT);
    end else if (soft_reset) begin
      start_cnt_q <= ($clog2(STARTUP_CNT+1))'(STARTUP_CNT); // [R22]
    end else if (!producing) begin
      start_cnt_q <= start_cnt_q - 1'b1;
    end
  end
  assign producing_o = producing;

  // FIR: one multiply-accumulate per cycle over all sensors and taps
  fir_state_e fir_state_q;
  logic [DATA_W-1:0] hist_q [SENSORS*TAPS];
  logic [TAP_W-1:0] wp_q, tap_q;
  logic [2:0] sensor_q;
  logic signed [39:0] acc_q;
  logic [SENSORS-1:0][DATA_W-1:0] fir_out_q;
  logic fir_valid_q;

  wire [2*SENSORS-1:0] bank_fields = {bank_high_q[3*BANK_FIELD_W-1:0],
                                      bank_low_q[3*BANK_FIELD_W-1:0]}; // [R5]
  wire [1:0] bank = bank_fields[sensor_q*BANK_FIELD_W +: BANK_FIELD_W];
  wire [TAP_W-1:0] hist_tap = (wp_q >= tap_q) ? wp_q - tap_q : wp_q + TAP_W'(TAPS) - tap_q;
  wire [COEF_IDX_W-1:0] mac_coef_idx = COEF_IDX_W'(bank) * COEF_IDX_W'(TAPS)
                                     + COEF_IDX_W'(tap_q); // [R3]
  localparam int HIST_IDX_W = $clog2(SENSORS*TAPS);
  wire [HIST_IDX_W-1:0] hist_idx = HIST_IDX_W'(sensor_q) * HIST_IDX_W'(TAPS)
                                 + HIST_IDX_W'(hist_tap);
  wire signed [31:0] product = $signed(hist_q[hist_idx]) * $signed(coef_q[mac_coef_idx]);
  wire signed [39:0] acc_next = acc_q + 40'(product);
  wire pop_on = calib_opt_q[POP_ENABLE_BIT];
  wire last_tap = (tap_q == TAP_W'(TAPS - 1));

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fir_state_q <= F_IDLE;
      wp_q <= '0;
      tap_q <= '0;
      sensor_q <= '0;
      acc_q <= '0;
      fir_out_q <= '0;
      fir_valid_q <= 1'b0;
    end else if (soft_reset) begin
      fir_state_q <= F_IDLE;
      fir_valid_q <= 1'b0;
    end else begin
      fir_valid_q <= 1'b0;
      case (fir_state_q)
        F_IDLE: if (sample_valid_i && producing) begin
          tap_q <= '0;
          sensor_q <= '0;
          acc_q <= '0;
          fir_state_q <= F_MAC;
        end
        F_MAC: begin
          tap_q <= last_tap ? '0 : tap_q + 1'b1;
          acc_q <= last_tap ? '0 : acc_next;
          if (last_tap) begin
            fir_out_q[sensor_q] <= acc_next[COEF_FRAC +: DATA_W]; // [R2]
            sensor_q <= sensor_q + 1'b1;
            if (sensor_q == 3'(SENSORS - 1)) fir_state_q <= F_DONE;
          end
        end
        F_DONE: begin
          fir_valid_q <= 1'b1;
          wp_q <= (wp_q == TAP_W'(TAPS - 1)) ? '0 : wp_q + 1'b1;
          fir_state_q <= F_IDLE;
        end
        default: fir_state_q <= F_IDLE;
      endcase
    end
  end

  // sample history and coefficient memories
  wire take_sample = (fir_state_q == F_IDLE) && sample_valid_i && producing && !soft_reset;
  wire coef_write = is_write && coef_word;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < SENSORS*TAPS; i++) hist_q[i] <= '0;
      for (int i = 0; i < BANKS*TAPS; i++) coef_q[i] <= COEF_PRESET; // [R4]
    end else begin
      // old history must not leak into the first outputs after a restart
      if (soft_reset) begin
        for (int i = 0; i < SENSORS*TAPS; i++) hist_q[i] <= '0; // [R22]
      end
      if (take_sample) begin
        for (int s = 0; s < 3; s++) begin
          hist_q[s*TAPS + int'(wp_q)] <= sample_i.gyro[s];
          hist_q[(s+3)*TAPS + int'(wp_q)] <= pop_on ?
            sample_i.accel[s] + pop_term_i[s] : sample_i.accel[s]; // [R1]
        end
      end
      if (coef_write) begin
        coef_q[host_coef_idx] <= merge_byte(coef_q[host_coef_idx], hi_byte, frame.data); // [R4]
      end
    end
  end

  // decimation
  logic avg_valid;
  logic [SENSORS-1:0][DATA_W-1:0] avg_data;
  sample_averager #(.CH(SENSORS), .W(DATA_W), .SUM_W(32)) u_averager (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .flush_i(soft_reset),
    .count_i(avg_count_q),
    .in_valid_i(fir_valid_q),
    .in_data_i(fir_out_q),
    .out_valid_o(avg_valid),
    .out_data_o(avg_data)
  ); // [R6]

  // output registers and data-ready pulse
  logic [$clog2(DR_PULSE_CYCLES+1)-1:0] dr_cnt_q;
  logic [3:0] pin_q, pin_oe_q;
  wire dr_active = (dr_cnt_q != '0);
  wire dr_level = pin_func_q[DR_IDLE_HIGH_BIT] ? !dr_active : dr_active; // [R19]
  wire [1:0] dr_pin = pin_func_q[DR_PIN_LSB +: DR_PIN_W]; // [R19]
  wire dr_enabled = pin_func_q[DR_ENABLE_BIT] && producing; // [R21]

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dr_cnt_q <= '0;
      out_q <= '0;
      pin_q <= 4'h0;
      pin_oe_q <= 4'h0;
    end else begin
      if (avg_valid && producing) begin
        out_q <= avg_data;
        dr_cnt_q <= ($clog2(DR_PULSE_CYCLES+1))'(DR_PULSE_CYCLES); // [R18]
      end else if (dr_active) begin
        dr_cnt_q <= dr_cnt_q - 1'b1;
      end
      for (int p = 0; p < 4; p++) begin
        pin_oe_q[p] <= dr_enabled && (dr_pin == 2'(p)); // [R18] [R19]
        pin_q[p] <= dr_enabled && (dr_pin == 2'(p)) && dr_level;
      end
    end
  end

  assign multipurpose_pin_o = pin_q;
  assign multipurpose_pin_oe_o = pin_oe_q;

endmodule : paged_spi_register_port
`default_nettype wire

// ---- core/sample_averager.sv ----
// decimating averager: sums a programmable number of samples per sensor
// assumes samples arrive as single-cycle strobes on the core clock
`timescale 1ns/100ps
`default_nettype none
module sample_averager
  import imu_port_pkg::*;
#(
  parameter int CH = SENSORS,
  parameter int W = DATA_W,
  parameter int SUM_W = 32
) (
  input wire logic clock_i,                  // core clock
  input wire logic resetn_i,                 // async reset, active low
  input wire logic flush_i,                  // drop partial sums
  input wire logic [15:0] count_i,           // samples per update
  input wire logic in_valid_i,               // new filtered set
  input wire logic [CH-1:0][W-1:0] in_data_i, // filtered samples
  output logic out_valid_o,                  // averaged set ready
  output logic [CH-1:0][W-1:0] out_data_o    // averaged samples
);

  logic [15:0] seen_q;
  logic [CH-1:0][SUM_W-1:0] sum_q;
  // a count of zero behaves as one so the divider never sees zero
  wire [15:0] count_eff = (count_i == 16'h0000) ? 16'h0001 : count_i;
  wire last_sample = (seen_q + 16'h0001) >= count_eff; // [R6]

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_q <= 16'h0000;
      out_valid_o <= 1'b0;
    end else if (flush_i) begin
      seen_q <= 16'h0000;
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= in_valid_i && last_sample;
      if (in_valid_i) begin
        seen_q <= last_sample ? 16'h0000 : seen_q + 16'h0001;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < CH; i++) begin : g_ch
      wire signed [SUM_W-1:0] total =
        $signed(sum_q[i]) + SUM_W'($signed(in_data_i[i]));
      wire signed [SUM_W-1:0] quot = total / $signed({{(SUM_W-16){1'b0}}, count_eff});
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sum_q[i] <= '0;
          out_data_o[i] <= '0;
        end else if (flush_i) begin
          sum_q[i] <= '0;
        end else if (in_valid_i) begin
          sum_q[i] <= last_sample ? '0 : total; // [R6]
          if (last_sample) begin
            out_data_o[i] <= quot[W-1:0];
          end
        end
      end
    end
  endgenerate

endmodule : sample_averager
`default_nettype wire

// ---- include/imu_port_pkg.sv ----
// package for the paged serial register port of the inertial sensor core
// assumes a 250 MHz core clock that oversamples the serial pins
//
// Overview of operation
// R1: point-of-percussion term only when option bit 6 set
// R2: samples pass FIR, then decimating averager
// R3: four coefficient banks of 120 taps each
// R4: banks preset at reset, each coefficient writable
// R5: two bank-choice registers pick each sensor's bank
// R6: averager divides update rate by its count
// R7: thirteen pages of 64 locations each
// R8: 16-bit registers, each byte separately addressed
// R9: serial port reaches only the active page
// R10: page select register writes and reads active page
// R11: page select sits at address 0x00 everywhere
// R12: fixed page code assignment, coefficients on 0x05-0x0C
// R13: output bits meaningful only after a read request
// R14: data output high impedance while chip select high
// R15: host is master, clock at most 15 MHz; bench host model runs at about 15.6 MHz
// R16: mode 3, clock idles high, sample second edge
// R17: 16-bit frames, most significant bit first
// R18: data ready on pin two, pulses low on update
// R19: data ready setup from pin function bits 3:0
// R20: host collects data when pulse returns high
// R21: ignore data ready until production begins
// R22: software reset bit 7 restarts data production
// R23: read answer comes in the following frame
// R24: read frame is R/W low, address, don't care
// R25: write frame is R/W high, address, one byte
// R26: writes to reserved page and outputs ignored
package imu_port_pkg;

  localparam int SENSORS = 6;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int FRAME_BITS = 16;
  localparam int BANKS = 4;
  localparam int TAPS = 120;
  localparam int COEF_PER_PAGE = 60;
  localparam int COEF_IDX_W = 9;
  localparam int TAP_W = 7;
  localparam int COEF_FRAC = 15;

  // page codes
  localparam logic [7:0] PG_OUTPUT = 8'h00;
  localparam logic [7:0] PG_RESERVED = 8'h01;
  localparam logic [7:0] PG_CALIB = 8'h02;
  localparam logic [7:0] PG_CONTROL = 8'h03;
  localparam logic [7:0] PG_SERIAL = 8'h04;
  localparam logic [7:0] PG_COEF_FIRST = 8'h05;
  localparam logic [7:0] PG_COEF_LAST = 8'h0C;

  // word indices within a page (byte address = 2 * index)
  localparam logic [5:0] REG_PAGE_SELECT = 6'h00;
  localparam logic [5:0] REG_OUT_BASE = 6'h08;
  localparam logic [5:0] REG_GLOBAL_CMD = 6'h01;
  localparam logic [5:0] REG_PIN_FUNCTION = 6'h03;
  localparam logic [5:0] REG_CALIB_OPTION = 6'h05;
  localparam logic [5:0] REG_AVG_COUNT = 6'h06;
  localparam logic [5:0] REG_BANK_LOW = 6'h0B;
  localparam logic [5:0] REG_BANK_HIGH = 6'h0C;
  localparam logic [5:0] REG_SERIAL = 6'h10;
  localparam logic [5:0] COEF_BASE_WORD = 6'h04;

  // bit positions
  localparam int POP_ENABLE_BIT = 6;
  localparam int SOFT_RESET_BIT = 7;
  localparam int DR_ENABLE_BIT = 3;
  localparam int DR_IDLE_HIGH_BIT = 2;
  localparam int DR_PIN_LSB = 0;
  localparam int DR_PIN_W = 2;
  localparam int BANK_FIELD_W = 2;

  // reset values
  localparam logic [15:0] PIN_FUNCTION_RESET = 16'h000D;
  localparam logic [15:0] CALIB_OPTION_RESET = 16'h0040;
  localparam logic [15:0] AVG_COUNT_RESET = 16'h0001;
  localparam logic [15:0] BANK_CHOICE_RESET = 16'h0000;
  localparam logic [15:0] COEF_PRESET = 16'h0111;

  // timing
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int DR_PULSE_NS = 1000;
  localparam int DR_PULSE_CYCLES = (DR_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int STARTUP_NS = 10000;
  localparam int STARTUP_CYCLES = (STARTUP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  typedef struct packed {
    logic [2:0][DATA_W-1:0] gyro;
    logic [2:0][DATA_W-1:0] accel;
  } sample_set_s;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } spi_frame_s;

endpackage : imu_port_pkg

// ---- tb/paged_spi_register_port_chk.sv ----
// assertion checker for the paged serial register port
// bound to the port module; sees its pins only
`timescale 1ns/100ps
`default_nettype none
module paged_spi_register_port_chk
  import imu_port_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES
) (
  input wire logic clock_i,                     // core clock
  input wire logic resetn_i,                    // async reset, active low
  input wire logic cs_n_i,                      // chip select pin
  input wire logic miso_o,                      // serial data out
  input wire logic miso_oe_o,                   // serial out enable
  input wire logic [3:0] multipurpose_pin_o,    // pin levels
  input wire logic [3:0] multipurpose_pin_oe_o, // pin enables
  input wire logic producing_o                  // production running
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] low_q;
  logic [15:0] idle_q;
  wire pin_low = multipurpose_pin_oe_o[1] && !multipurpose_pin_o[1];
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_q <= 16'h0000;
      idle_q <= 16'h0000;
    end else begin
      low_q <= pin_low ? low_q + 16'h0001 : 16'h0000;
      idle_q <= producing_o ? 16'h0000 : idle_q + 16'h0001;
    end
  end
  a_miso_release: assert property (cs_n_i [*3] |-> !miso_oe_o)
    else $error("serial out driven while deselected");
  a_miso_select: assert property (!cs_n_i [*3] |-> miso_oe_o)
    else $error("serial out not driven while selected");
  a_miso_quiet: assert property (!miso_oe_o |-> !miso_o)
    else $error("serial out not parked low");
  // short low spans at start-up are not pulses
  a_pulse_len: assert property ($rose(multipurpose_pin_o[1]) && low_q > 16'h0008
    |-> low_q == DR_PULSE_CYCLES) else $error("ready pulse length wrong");
  a_pulse_bound: assert property (low_q <= DR_PULSE_CYCLES)
    else $error("ready pulse too long");
  a_pin_single: assert property ($onehot0(multipurpose_pin_oe_o))
    else $error("more than one pin driven");
  a_ready_held: assert property (!producing_o && !$past(producing_o)
    |-> multipurpose_pin_oe_o == 4'h0) else $error("ready pin driven before production");
  a_startup_len: assert property ($rose(producing_o)
    |-> idle_q >= STARTUP_CNT - 2 && idle_q <= STARTUP_CNT + 2)
    else $error("start-up count wrong");
endmodule : paged_spi_register_port_chk
`default_nettype wire

// ---- tb/paged_spi_register_port_test.sv ----
// self-checking bench: paging, byte writes, presets, data ready, soft reset
// core inputs change at the falling clock edge; the host model drives the serial pins
`timescale 1ns/100ps
`default_nettype none
module paged_spi_register_port_test;
  import imu_port_pkg::*;
  localparam int START = 20; // short start-up for simulation
  localparam logic [15:0] SN = 16'h5A3C; // arbitrary value
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sample_valid_i = 1'b0;
  sample_set_s sample_i = '0;
  logic [2:0][DATA_W-1:0] pop_term_i = '0;
  logic sclk, cs_n, mosi, miso, miso_oe, producing;
  logic [3:0] pin, pin_oe;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000BE9A;
  logic [15:0] d, g, a, p, g2, a2;
  initial forever #2 clock_i = ~clock_i;
  spi_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe));
  paged_spi_register_port #(.SERIAL_NUMBER(SN), .STARTUP_CNT(START)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .sample_valid_i(sample_valid_i),
    .sample_i(sample_i), .pop_term_i(pop_term_i), .multipurpose_pin_o(pin),
    .multipurpose_pin_oe_o(pin_oe), .producing_o(producing));
  function automatic logic [15:0] rs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return {{2{seed[13]}}, seed[13:0]}; // small enough that sums never wrap
  endfunction : rs
  // all taps preset alike, so the output is the history sum times the preset
  function automatic logic [15:0] fo(input logic signed [17:0] s);
    logic signed [31:0] acc;
    acc = s;
    acc = acc * 32'(COEF_PRESET);
    return acc[30:15];
  endfunction : fo
  function automatic logic [15:0] av(input logic [15:0] x, input logic [15:0] y);
    logic signed [16:0] s;
    s = $signed(x) + $signed(y);
    s = s / 17'sd2;
    return s[15:0];
  endfunction : av
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [6:0] ad, input logic [7:0] b);
    logic [15:0] x;
    i_host.xfer({1'b1, ad, b}, x);
  endtask : wr
  task automatic rc(input string w, input logic [6:0] ad, input logic [15:0] e);
    logic [15:0] x;
    i_host.xfer({1'b0, ad, 8'h00}, x);
    i_host.xfer(16'h0000, x); // answer comes in the next frame
    check(w, x, e);
  endtask : rc
  task automatic wait_prod();
    int n;
    n = 0;
    while (producing !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    check("production start", {15'h0000, producing}, 16'h0001);
  endtask : wait_prod
  task automatic pulse(input logic [15:0] gv, input logic [15:0] accv);
    @(negedge clock_i);
    sample_i = {rs(), rs(), gv, rs(), rs(), accv};
    sample_valid_i = 1'b1;
    @(negedge clock_i);
    sample_valid_i = 1'b0;
  endtask : pulse
  task automatic wait_dr();
    int n;
    n = 0;
    while (!(pin_oe[1] === 1'b1 && pin[1] === 1'b0) && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    check("ready pulse", {15'h0000, n < 3000}, 16'h0001);
    while (pin[1] !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
  endtask : wait_dr
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    wait_prod();
    rc("page select", 7'h00, 16'h0000);
    wr({REG_OUT_BASE, 1'b0}, 8'hFF);
    i_host.xfer(16'h0000, d);
    check("after write", d, 16'h0000);
    rc("output word", {REG_OUT_BASE, 1'b0}, 16'h0000);
    wr(7'h00, PG_CONTROL);
    rc("page select", 7'h01, 16'h0003);
    rc("pin function", {REG_PIN_FUNCTION, 1'b0}, PIN_FUNCTION_RESET);
    rc("calib option", {REG_CALIB_OPTION, 1'b0}, CALIB_OPTION_RESET);
    rc("avg count", {REG_AVG_COUNT, 1'b0}, AVG_COUNT_RESET);
    rc("bank low", {REG_BANK_LOW, 1'b0}, BANK_CHOICE_RESET);
    rc("bank high", {REG_BANK_HIGH, 1'b1}, BANK_CHOICE_RESET);
    for (int pg = 5; pg <= 12; pg++) begin // every coefficient page
      wr(7'h00, 8'(pg));
      rc("coef preset", {COEF_BASE_WORD, 1'b0}, COEF_PRESET);
    end
    rc("last tap", 7'h7E, COEF_PRESET);
    wr(7'h00, 8'h07); // bank b is unused by default, so writes leave the data path alone
    rc("other page", {REG_BANK_LOW, 1'b0}, COEF_PRESET);
    g = rs();
    wr({COEF_BASE_WORD, 1'b0}, g[7:0]);
    rc("coef low byte", {COEF_BASE_WORD, 1'b1}, {COEF_PRESET[15:8], g[7:0]});
    wr({COEF_BASE_WORD, 1'b1}, g[15:8]);
    rc("coef word", {COEF_BASE_WORD, 1'b0}, g);
    wr(7'h00, PG_SERIAL);
    wr({REG_SERIAL, 1'b0}, ~SN[7:0]);
    rc("serial number", {REG_SERIAL, 1'b0}, SN);
    g = rs();
    a = rs();
    p = rs();
    pop_term_i = {p, p, p};
    pulse(g, a);
    wait_dr(); // collect only once the pulse is back high
    wr(7'h00, PG_OUTPUT);
    rc("gyro out", {REG_OUT_BASE, 1'b0}, fo($signed(g)));
    rc("accel out", {REG_OUT_BASE + 6'h03, 1'b0}, fo($signed(a) + $signed(p)));
    wr(7'h00, PG_CONTROL);
    wr({REG_GLOBAL_CMD, 1'b0}, 8'h80);
    wait_prod();
    wr({REG_CALIB_OPTION, 1'b0}, 8'h00);
    wr({REG_AVG_COUNT, 1'b0}, 8'h02);
    g = rs();
    a = rs();
    g2 = rs();
    a2 = rs();
    pulse(g, a);
    repeat (800) @(negedge clock_i);
    pulse(g2, a2);
    wait_dr();
    wr(7'h00, PG_OUTPUT);
    rc("gyro avg", {REG_OUT_BASE, 1'b0}, av(fo($signed(g)), fo($signed(g) + $signed(g2))));
    rc("accel avg", {REG_OUT_BASE + 6'h03, 1'b0}, av(fo($signed(a)), fo($signed(a) + $signed(a2))));
    end_sim();
  end
endmodule : paged_spi_register_port_test
bind paged_spi_register_port paged_spi_register_port_chk #(.STARTUP_CNT(STARTUP_CNT)) i_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .multipurpose_pin_o(multipurpose_pin_o),
  .multipurpose_pin_oe_o(multipurpose_pin_oe_o), .producing_o(producing_o));
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// host-side serial master: mode 3, 16-bit frames, msb first
// the bench calls xfer once per frame; clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic sclk_o,     // serial clock, idles high
  output logic cs_n_o,     // chip select, active low
  output logic mosi_o,     // data to device
  input wire logic miso_i, // device data out
  input wire logic miso_oe_i // device drive enable
);
  localparam realtime HALF = 32.0; // 64 ns period, about 15.6 MHz, just above the 15 MHz ceiling
  wire line = miso_oe_i ? miso_i : 1'bz;
  initial begin
    sclk_o = 1'b1; // idle high
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
    cs_n_o = 1'b0;
    #(HALF);
    for (int i = 15; i >= 0; i--) begin // msb first, 16 bits
      sclk_o = 1'b0;
      mosi_o = din[i];
      #(HALF);
      sclk_o = 1'b1;
      dout[i] = line; // taken on the rising edge
      #(HALF);
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not show a stale bit
    #(HALF * 2);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire
